// ==== core/hsh_pkg.sv ====
/*
  package for the home-switch homing search: mode codes, search states, reset values.
  assumes a single synchronous clock domain; no software registers.
*/
`default_nettype none
package hsh_pkg;
  // ==========================================================
  // homing variant codes
  localparam logic [7:0] HSH_M_POS_ZP0   = 8'h03;
  localparam logic [7:0] HSH_M_POS_ZP1   = 8'h04;
  localparam logic [7:0] HSH_M_NEG_ZP0   = 8'h05;
  localparam logic [7:0] HSH_M_NEG_ZP1   = 8'h06;
  localparam logic [7:0] HSH_M_POS_FALL  = 8'h13;
  localparam logic [7:0] HSH_M_POS_RISE  = 8'h14;
  localparam logic [7:0] HSH_M_NEG_FALL  = 8'h15;
  localparam logic [7:0] HSH_M_NEG_RISE  = 8'h16;
  localparam logic [7:0] HSH_M_RPOS_LO   = 8'h17;
  localparam logic [7:0] HSH_M_RPOS_HI   = 8'h1a;
  localparam logic [7:0] HSH_M_RNEG_LO   = 8'h1b;
  localparam logic [7:0] HSH_M_RNEG_HI   = 8'h1e;
  // ==========================================================
  // reset values
  localparam logic       HSH_DIR_RST     = 1'b0;
  localparam logic [7:0] HSH_MODE_RST    = 8'h13;
  typedef enum logic [2:0] {
    HSH_IDLE, HSH_SEARCH, HSH_BRAKE, HSH_DONE, HSH_FAULT
  } hsh_state_e;
endpackage
`default_nettype wire

// ==== core/hsh_edge_det.sv ====
/*
  edge detector for the home switch and the index pulse.
  assumes inputs already in the clk_sys domain.
*/
`default_nettype none
module hsh_edge_det #(
  parameter int W = 2
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] sig_in,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] prev_r;
  logic [W-1:0] prev_nxt;
  always_comb begin
    prev_nxt = sig_in;
  end
  // history follows the pin through reset, so a pin that idles high gives no
  // false edge at release; edges are only hidden while reset is held
  always_ff @(posedge clk_sys) begin
    prev_r <= prev_nxt;
  end
  assign rise = rst_n ? (sig_in & ~prev_r) : '0;
  assign fall = rst_n ? (~sig_in & prev_r) : '0;
endmodule
`default_nettype wire

// ==== core/hsh_homing_search.sv ====
/*
  homing search with a home switch: picks direction, reverses at end of travel,
  captures the machine reference on a switch edge or a qualified index pulse.
  assumes switch and index inputs are synchronous to clk_sys; the profile
  generator follows search_active, dir_neg and brake_req and reports stopped.
*/
// What this block does
// - positive-side modes: switch low on negative side, high on positive side.
// - negative-side modes: switch high on negative side, low on positive side.
// - modes 19,20,3,4 start positive when switch reads 0.
// - modes 21,22,5,6 start negative when switch reads 0.
// - modes 19,21 capture reference at switch falling edge, ignore index.
// - modes 20,22 capture reference at switch rising edge, ignore index.
// - modes 3,5 capture first index pulse while switch reads 0.
// - modes 4,6 capture first index pulse while switch reads 1.
// - reversal-switch modes expect switch active mid-travel, inactive either side.
// - configuration chooses which reversal input serves which travel end.
// - modes 23 to 26 use switch and positive-end reversal, no index.
// - modes 27 to 30 use switch and negative-end reversal, no index.
// - without reversal switches, the run may use the end stop via current threshold.
// - current at threshold decelerates axis and reverses its direction.
// - all switch conditions are evaluated after configured inversion.
// - the motor zero point is the once-per-revolution index pulse.
`default_nettype none
module hsh_homing_search
  import hsh_pkg::*;
#(
  parameter int POS_W = 32,
  parameter int CUR_W = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             start,
  input  wire logic [7:0]       homing_variant_select,
  input  wire logic             home_switch,
  input  wire logic             home_inv,
  input  wire logic             rev_a,
  input  wire logic             rev_b,
  input  wire logic             rev_inv,
  input  wire logic             rev_swap,
  input  wire logic             cur_rev_en,
  input  wire logic [CUR_W-1:0] cur_thresh,
  input  wire logic [CUR_W-1:0] motor_current,
  input  wire logic             index_pulse,
  input  wire logic             stopped,
  input  wire logic [POS_W-1:0] actual_pos,
  output logic                  search_active,
  output logic                  dir_neg,
  output logic                  brake_req,
  output logic                  referenced,
  output logic                  mode_fault,
  output logic      [POS_W-1:0] machine_reference
);
  // ==========================================================
  // conditioned inputs
  logic sw, rev_pos, rev_neg, sw_rise, sw_fall, idx_rise;
  logic [1:0] e_rise, e_fall;
  assign sw      = home_switch ^ home_inv;
  assign rev_pos = (rev_swap ? rev_a : rev_b) ^ rev_inv;
  assign rev_neg = (rev_swap ? rev_b : rev_a) ^ rev_inv;

  hsh_edge_det #(.W(2)) hsh_edge_det_i (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .sig_in  ({index_pulse, sw}),
    .rise    (e_rise),
    .fall    (e_fall)
  );
  assign sw_rise  = e_rise[0];
  assign sw_fall  = e_fall[0];
  assign idx_rise = e_rise[1];

  // ==========================================================
  // mode decode from the latched code
  logic [7:0] mode_r, mode_nxt;
  logic m_pos, m_neg, m_fall, m_rise, m_zp0, m_zp1, m_rpos, m_rneg, m_ok;
  always_comb begin
    m_pos  = mode_r inside {HSH_M_POS_FALL, HSH_M_POS_RISE, HSH_M_POS_ZP0, HSH_M_POS_ZP1};
    m_neg  = mode_r inside {HSH_M_NEG_FALL, HSH_M_NEG_RISE, HSH_M_NEG_ZP0, HSH_M_NEG_ZP1};
    m_fall = mode_r inside {HSH_M_POS_FALL, HSH_M_NEG_FALL};
    m_rise = mode_r inside {HSH_M_POS_RISE, HSH_M_NEG_RISE};
    m_zp0  = mode_r inside {HSH_M_POS_ZP0, HSH_M_NEG_ZP0};
    m_zp1  = mode_r inside {HSH_M_POS_ZP1, HSH_M_NEG_ZP1};
    m_rpos = mode_r >= HSH_M_RPOS_LO && mode_r <= HSH_M_RPOS_HI;
    m_rneg = mode_r >= HSH_M_RNEG_LO && mode_r <= HSH_M_RNEG_HI;
    m_ok   = m_pos | m_neg | m_rpos | m_rneg;
  end

  // ==========================================================
  // search sequencer
  hsh_state_e state_r, state_nxt;
  logic dir_r, dir_nxt, ref_r, ref_nxt, flt_r, flt_nxt, ovr_r, ovr_nxt;
  logic [POS_W-1:0] pos_r, pos_nxt;
  logic hit, rev_hit, cur_hit, odd_bit;

  // reversal-switch modes 23..30: even low bit = rising edge, odd = falling.
  // the switch sits mid-travel, so either edge is met whichever way we came.
  assign odd_bit = mode_r[0];
  assign cur_hit = cur_rev_en && (motor_current >= cur_thresh);
  assign rev_hit = dir_r ? rev_neg : rev_pos;

  always_comb begin
    hit = 1'b0;
    if (m_fall) begin
      hit = sw_fall;
    end else if (m_rise) begin
      hit = sw_rise;
    end else if (m_zp0) begin
      hit = idx_rise && !sw;
    end else if (m_zp1) begin
      hit = idx_rise && sw;
    end else if (m_rpos || m_rneg) begin
      hit = odd_bit ? sw_fall : sw_rise;
    end
  end

  always_comb begin
    state_nxt = state_r;
    mode_nxt  = mode_r;
    dir_nxt   = dir_r;
    ref_nxt   = ref_r;
    flt_nxt   = flt_r;
    pos_nxt   = pos_r;
    ovr_nxt   = ovr_r;
    unique case (state_r)
      HSH_IDLE, HSH_DONE, HSH_FAULT: begin
        if (start) begin
          mode_nxt = homing_variant_select;
          ref_nxt  = 1'b0;
          flt_nxt  = 1'b0;
          ovr_nxt  = 1'b0;
          state_nxt = HSH_SEARCH;
        end
      end
      HSH_SEARCH: begin
        if (!m_ok) begin
          flt_nxt   = 1'b1;
          state_nxt = HSH_FAULT;
        end else if (!ovr_r) begin
          ovr_nxt = 1'b1;
          // direction from the switch level at the start of the run, or from the mode in reversal-switch modes
          if (m_pos) begin
            dir_nxt = sw;
          end else if (m_neg) begin
            dir_nxt = !sw;
          end else begin
            dir_nxt = m_rneg;
          end
        end else if (hit) begin
          pos_nxt   = actual_pos;
          ref_nxt   = 1'b1;
          state_nxt = HSH_DONE;
        end else if (rev_hit || cur_hit) begin
          state_nxt = HSH_BRAKE;
        end
      end
      HSH_BRAKE: begin
        if (stopped) begin
          dir_nxt   = !dir_r;
          state_nxt = HSH_SEARCH;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= HSH_IDLE;
      mode_r  <= HSH_MODE_RST;
      dir_r   <= HSH_DIR_RST;
      ref_r   <= 1'b0;
      flt_r   <= 1'b0;
      ovr_r   <= 1'b0;
      pos_r   <= '0;
    end else begin
      state_r <= state_nxt;
      mode_r  <= mode_nxt;
      dir_r   <= dir_nxt;
      ref_r   <= ref_nxt;
      flt_r   <= flt_nxt;
      ovr_r   <= ovr_nxt;
      pos_r   <= pos_nxt;
    end
  end

  // the first search cycle only sets direction, so motion waits one clock
  assign search_active     = (state_r == HSH_SEARCH) && ovr_r;
  assign brake_req         = (state_r == HSH_BRAKE);
  assign dir_neg           = dir_r;
  assign referenced        = ref_r;
  assign mode_fault        = flt_r;
  assign machine_reference = pos_r;

  // ==========================================================
  // checks
  sequence s_capture;
    search_active && hit;
  endsequence

  a_capture_sets_ref: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_capture |=> referenced && !search_active) else $error("capture did not reference");
  a_capture_pos: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_capture |=> machine_reference == $past(actual_pos)) else $error("wrong reference pos");
  a_fall_mode_idx: assert property (@(posedge clk_sys) disable iff (!rst_n)
    search_active && m_fall && !sw_fall |=> !referenced) else $error("index used in edge mode");
  a_rise_mode_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
    search_active && m_rise && sw_rise |=> referenced) else $error("rise edge missed");
  a_zp0_qualify: assert property (@(posedge clk_sys) disable iff (!rst_n)
    search_active && m_zp0 && idx_rise && sw |=> !referenced) else $error("index at switch 1");
  a_zp1_qualify: assert property (@(posedge clk_sys) disable iff (!rst_n)
    search_active && m_zp1 && idx_rise && !sw |=> !referenced) else $error("index at switch 0");
  a_start_pos_dir: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == HSH_SEARCH && !ovr_r && m_pos && !sw |=> !dir_neg) else $error("bad start dir");
  a_start_neg_dir: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == HSH_SEARCH && !ovr_r && m_neg && !sw |=> dir_neg) else $error("bad start dir");
  sequence s_threshold_trip;
    search_active && !hit && cur_rev_en && (motor_current >= cur_thresh);
  endsequence
  sequence s_brake_done;
    brake_req && stopped;
  endsequence

  a_cur_brake: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_threshold_trip |=> brake_req && !search_active) else $error("no brake at threshold");
  a_cur_reverse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_brake_done |=> search_active && dir_neg != $past(dir_neg))
    else $error("no reversal after brake");
  a_bad_mode_fault: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == HSH_SEARCH && !m_ok |=> mode_fault && !search_active)
    else $error("unknown mode not refused");
  a_mode_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_r == HSH_SEARCH |=> $stable(mode_r)) else $error("mode changed in run");
endmodule
`default_nettype wire

// ==== verification/hsh_axis_model.sv ====
/*
  behavioural axis for the homing search: position, home switch, end switches,
  index pulse, stall current and a profile that stops two cycles after brake.
  assumes it is clocked with the search block and loaded by the bench while idle.
*/
`default_nettype none
module hsh_axis_model (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        search_active,
  input  wire logic        dir_neg,
  input  wire logic        brake_req,
  input  wire logic        load,
  input  wire logic [31:0] load_pos,
  input  wire logic [1:0]  layout,
  input  wire logic        home_inv,
  input  wire logic        rev_swap,
  input  wire logic        no_rev,
  output logic             home_switch,
  output logic             index_pulse,
  output logic             stopped,
  output logic             rev_a,
  output logic             rev_b,
  output logic [15:0]      motor_current,
  output logic [31:0]      actual_pos
);
  // ==========================================================
  // motion and sensors
  logic [31:0] pos_r;
  logic [1:0]  brk_r;
  logic        hs, neg_end, pos_end;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pos_r <= 32'h0;
      brk_r <= 2'h0;
    end else begin
      // one count per cycle keeps the homing speed low
      if (load) pos_r <= load_pos;
      else if (search_active && !brake_req) pos_r <= dir_neg ? pos_r - 32'h1 : pos_r + 32'h1;
      brk_r <= !brake_req ? 2'h0 : (brk_r == 2'h2) ? brk_r : brk_r + 2'h1;
    end
  end
  assign hs = (layout == 2'h0) ? (pos_r >= 32'h2c) :
              (layout == 2'h1) ? (pos_r < 32'h2c) : (pos_r >= 32'h28 && pos_r < 32'h30);
  assign home_switch = hs ^ home_inv;
  // index every 8 counts, one pulse per revolution
  assign index_pulse = (pos_r[2:0] == 3'h0);
  assign stopped = (brk_r == 2'h2);
  assign neg_end = !no_rev && pos_r <= 32'h8;
  assign pos_end = !no_rev && pos_r >= 32'h50;
  assign rev_a = (rev_swap ? pos_end : neg_end) ^ home_inv;
  assign rev_b = (rev_swap ? neg_end : pos_end) ^ home_inv;
  // current rises only when pushing into a stop, never from acceleration
  assign motor_current = ((pos_r >= 32'h50 && !dir_neg) || (pos_r <= 32'h8 && dir_neg)) ?
                         16'h00c8 : 16'h0000;
  assign actual_pos = pos_r;
endmodule
`default_nettype wire

// ==== verification/hsh_homing_search_tb.sv ====
/*
  self-checking bench for the homing search: every mode code, both switch layouts,
  middle layout with end switches or stall current, inversion, swap, bad mode.
  assumes the axis model for the far side; expected positions follow its geometry.
*/
`default_nettype none
module hsh_homing_search_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import hsh_pkg::*;
  // ==========================================================
  // signals and instances
  logic clk_sys = 1'b0, rst_n = 1'b0, start = 1'b0, home_inv = 1'b0, rev_swap = 1'b0;
  logic cur_rev_en = 1'b0, load = 1'b0, no_rev = 1'b0;
  logic [1:0]  layout = 2'h0;
  logic [7:0]  homing_variant_select = 8'h13;
  logic [31:0] load_pos = 32'h0;
  logic home_switch, rev_a, rev_b, index_pulse, stopped, search_active, dir_neg;
  logic brake_req, referenced, mode_fault;
  logic [15:0] motor_current;
  logic [31:0] actual_pos, machine_reference;
  int err_total = 0;
  int cmp_count = 0;
  always #5 clk_sys = ~clk_sys;
  hsh_homing_search hsh_homing_search_i (.clk_sys, .rst_n, .start, .homing_variant_select,
    .home_switch, .home_inv, .rev_a, .rev_b, .rev_inv(home_inv), .rev_swap, .cur_rev_en,
    .cur_thresh(16'h0064), .motor_current, .index_pulse, .stopped, .actual_pos,
    .search_active, .dir_neg, .brake_req, .referenced, .mode_fault, .machine_reference);
  hsh_axis_model hsh_axis_model_i (.clk_sys, .rst_n, .search_active, .dir_neg, .brake_req,
    .load, .load_pos, .layout, .home_inv, .rev_swap, .no_rev, .home_switch, .index_pulse,
    .stopped, .rev_a, .rev_b, .motor_current, .actual_pos);
  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic kick(input logic [7:0] m, input logic [31:0] p0);
    homing_variant_select = m;
    load_pos = p0;
    load = 1'b1;
    @(negedge clk_sys);
    load = 1'b0;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic run(input logic [7:0] m, input logic [1:0] lay, input logic inv, sw, cr,
                     input logic [31:0] p0, input logic dn, input logic [31:0] rf);
    int n;
    logic saw;
    n = 0;
    saw = 1'b0;
    layout = lay;
    home_inv = inv;
    rev_swap = sw;
    no_rev = cr;
    cur_rev_en = cr;
    kick(m, p0);
    chk("dir_neg", dir_neg, dn);
    chk("search_active", search_active, 1'b1);
    while (referenced !== 1'b1 && n < 400) begin
      saw = saw | (brake_req === 1'b1);
      @(negedge clk_sys);
      n++;
    end
    chk("brake_req seen", saw, lay == 2'h2);
    chk("referenced", referenced, 1'b1);
    chk("machine_reference", machine_reference, rf);
    chk("search_active", search_active, 1'b0);
  endtask
  task automatic bad_mode;
    kick(8'h07, 32'h14);
    @(negedge clk_sys);
    chk("mode_fault", mode_fault, 1'b1);
    chk("search_active", search_active, 1'b0);
  endtask
  task automatic mid_reset;
    layout = 2'h0;
    kick(8'h13, 32'h3c);
    chk("dir_neg", dir_neg, 1'b1);
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b0;
    @(negedge clk_sys);
    rst_n = 1'b1;
    chk("search_active", search_active, 1'b0);
    chk("brake_req", brake_req, 1'b0);
    chk("dir_neg", dir_neg, 1'b0);
    chk("referenced", referenced, 1'b0);
    chk("machine_reference", machine_reference, 32'h0);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    #200us;
    err_total++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    chk("referenced", referenced, 1'b0);
    chk("search_active", search_active, 1'b0);
    chk("mode_fault", mode_fault, 1'b0);
    run(8'h13, 2'h0, 1'b0, 1'b0, 1'b0, 32'h3c, 1'b1, 32'h2b);
    run(8'h14, 2'h0, 1'b0, 1'b0, 1'b0, 32'h14, 1'b0, 32'h2c);
    run(8'h15, 2'h1, 1'b0, 1'b0, 1'b0, 32'h14, 1'b0, 32'h2c);
    run(8'h16, 2'h1, 1'b1, 1'b0, 1'b0, 32'h3c, 1'b1, 32'h2b);
    bad_mode();
    run(8'h03, 2'h0, 1'b1, 1'b0, 1'b0, 32'h14, 1'b0, 32'h18);
    run(8'h04, 2'h0, 1'b0, 1'b0, 1'b0, 32'h14, 1'b0, 32'h30);
    run(8'h05, 2'h1, 1'b0, 1'b0, 1'b0, 32'h3c, 1'b1, 32'h38);
    run(8'h06, 2'h1, 1'b0, 1'b0, 1'b0, 32'h3c, 1'b1, 32'h28);
    run(8'h17, 2'h2, 1'b0, 1'b0, 1'b0, 32'h3c, 1'b0, 32'h27);
    run(8'h18, 2'h2, 1'b0, 1'b0, 1'b1, 32'h3c, 1'b0, 32'h2f);
    run(8'h19, 2'h2, 1'b1, 1'b1, 1'b0, 32'h3c, 1'b0, 32'h27);
    run(8'h1a, 2'h2, 1'b0, 1'b1, 1'b0, 32'h3c, 1'b0, 32'h2f);
    run(8'h1b, 2'h2, 1'b0, 1'b0, 1'b0, 32'h14, 1'b1, 32'h30);
    run(8'h1c, 2'h2, 1'b1, 1'b0, 1'b0, 32'h14, 1'b1, 32'h28);
    run(8'h1d, 2'h2, 1'b0, 1'b1, 1'b0, 32'h14, 1'b1, 32'h30);
    run(8'h1e, 2'h2, 1'b0, 1'b0, 1'b1, 32'h14, 1'b1, 32'h28);
    mid_reset();
    run(8'h14, 2'h0, 1'b0, 1'b0, 1'b0, 32'h14, 1'b0, 32'h2c);
    report_and_stop();
  end
endmodule
`default_nettype wire
